// ---- rtl/coarc_pkg.sv ----
// package of constants and types for the clock output adjust / reset control block
// assumes a 100 MHz core clock and an 8-bit register port driven by the serial front end
package coarc_pkg;
	// ==========================================================
	// register map
	localparam logic [7:0] SOFT_RESET_CONTROL_ADDR = 8'hf6;
	localparam logic [7:0] SOFT_RESET_VALUE = 8'h02;
	localparam int SOFT_RESET_BIT = 1;
	localparam logic [7:0] SOFT_RESET_CONTROL_RST = 8'h00;
	// ==========================================================
	// output configuration fields
	localparam int NUM_OUT = 4;
	localparam logic [1:0] DIS_STATE_TRISTATE = 2'h0;
	localparam logic [1:0] DIS_STATE_ALWAYS_ON = 2'h3;
	localparam int DIV_SEL_W = 3;
	localparam logic [2:0] DIV_SEL_MAX = 3'h5;
	localparam int STEP_W = 24;
	// one bit wider than 2250 needs, so the saturation limits stay positive and negative
	localparam int PHASE_W = 13;
	localparam logic signed [12:0] PHASE_MAX = 13'sh08ca;
	localparam logic signed [12:0] PHASE_MIN = -13'sh08ca;
	// ==========================================================
	// timing
	localparam int CLK_HZ = 100_000_000;
	localparam int LOCK_WAIT_MS = 25;
	localparam int LOCK_WAIT_CYC = CLK_HZ / 1000 * LOCK_WAIT_MS;
	localparam int PIN_RATE_HZ = 1_500_000;
	localparam int PIN_GAP_CYC = (CLK_HZ + PIN_RATE_HZ - 1) / PIN_RATE_HZ;
	localparam int CAL_CYC = 16;
	// ==========================================================
	// sequencer states
	typedef enum logic [2:0] {
		COARC_IDLE,
		COARC_OFF,
		COARC_CAL,
		COARC_LOCK,
		COARC_ON
	} coarc_state_t;
endpackage

// ---- rtl/coarc_chan_if.sv ----
// interface carrying the per-output step commands to the channel accumulator
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface coarc_chan_if;
	import coarc_pkg::*;
	logic freq_up;
	logic freq_dn;
	logic phase_up;
	logic phase_dn;
	logic load;
	logic [STEP_W-1:0] freq_step;
	logic signed [PHASE_W-1:0] phase_step;
	logic signed [PHASE_W-1:0] phase_init;
	logic [DIV_SEL_W-1:0] div_sel;
	logic signed [STEP_W+7:0] freq_offset;
	logic signed [PHASE_W-1:0] phase_now;
	modport ctrl (output freq_up, freq_dn, phase_up, phase_dn, load, freq_step, phase_step,
		phase_init, div_sel, input freq_offset, phase_now);
	modport chan (input freq_up, freq_dn, phase_up, phase_dn, load, freq_step, phase_step,
		phase_init, div_sel, output freq_offset, phase_now);
endinterface
`default_nettype wire

// ---- rtl/coarc_chan.sv ----
// per-output accumulator of frequency and phase steps
// assumes step commands are single-cycle pulses from the controller
`timescale 1ns/1ps
`default_nettype none
module coarc_chan
	import coarc_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	coarc_chan_if.chan ch
);
	logic signed [STEP_W+7:0] freq_reg, freq_next;
	logic signed [PHASE_W-1:0] phase_reg, phase_next;
	logic signed [PHASE_W:0] phase_sum;
	logic signed [STEP_W+7:0] step_ext;

	// ==========================================================
	// step accumulation
	// frequency step is shifted right by the post divider select before the add, so divided outputs take smaller frequency steps; phase steps are not shifted
	always_comb begin
		step_ext = (STEP_W+8)'($signed({1'b0, ch.freq_step}) >>> ch.div_sel);
		freq_next = freq_reg;
		phase_next = phase_reg;
		phase_sum = {phase_reg[PHASE_W-1], phase_reg};
		if (ch.load) begin
			freq_next = '0;
			phase_next = (ch.div_sel == '0) ? ch.phase_init : '0;
		end else begin
			if (ch.freq_up && !ch.freq_dn)
				freq_next = freq_reg + step_ext;
			else if (ch.freq_dn && !ch.freq_up)
				freq_next = freq_reg - step_ext;
			if (ch.phase_up && !ch.phase_dn)
				phase_sum = phase_sum + ch.phase_step;
			else if (ch.phase_dn && !ch.phase_up)
				phase_sum = phase_sum - ch.phase_step;
			// saturate to the +/-45 ns window
			if (phase_sum > PHASE_MAX)
				phase_next = PHASE_MAX;
			else if (phase_sum < PHASE_MIN)
				phase_next = PHASE_MIN;
			else
				phase_next = phase_sum[PHASE_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			freq_reg <= '0;
			phase_reg <= '0;
		end else begin
			freq_reg <= freq_next;
			phase_reg <= phase_next;
		end
	end

	assign ch.freq_offset = freq_reg;
	assign ch.phase_now = phase_reg;
endmodule
`default_nettype wire

// ---- rtl/coarc_ctrl.sv ----
// top of the clock output adjust / reset control block
// assumes a serial front end that delivers byte writes and reads on a simple port,
// and analog synthesis that follows the enables, align and offset outputs.
`timescale 1ns/1ps
`default_nettype none
module coarc_ctrl
	import coarc_pkg::*;
#(
	parameter int LOCK_CYCLES = LOCK_WAIT_CYC,
	parameter bit LATER_REV = 1'b1
)(
	input wire logic clk,
	input wire logic resetn,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic lock_wait_bypass,
	input wire logic [2*NUM_OUT-1:0] dis_state,
	input wire logic [NUM_OUT-1:0] out_invert,
	input wire logic [NUM_OUT*DIV_SEL_W-1:0] output_post_divider,
	input wire logic [NUM_OUT-1:0] freq_up_cmd,
	input wire logic [NUM_OUT-1:0] freq_dn_cmd,
	input wire logic [NUM_OUT-1:0] phase_up_cmd,
	input wire logic [NUM_OUT-1:0] phase_dn_cmd,
	input wire logic [STEP_W-1:0] freq_step_size,
	input wire logic [PHASE_W-1:0] phase_step_size,
	input wire logic [NUM_OUT*PHASE_W-1:0] phase_init,
	input wire logic freq_step_up_pin,
	input wire logic freq_step_down_pin,
	input wire logic phase_step_up_pin,
	input wire logic phase_step_down_pin,
	input wire logic zero_delay_en,
	input wire logic [1:0] zero_delay_sel,
	input wire logic [NUM_OUT-1:0] spread_en,
	input wire logic [NUM_OUT-1:0] spread_center,
	input wire logic [NUM_OUT-1:0] host_spread_prog,
	output logic [NUM_OUT-1:0] out_enable,
	output logic [NUM_OUT-1:0] align_req,
	output logic [NUM_OUT-1:0] align_falling,
	output logic cal_busy,
	output logic [NUM_OUT-1:0] feedback_route,
	output logic [NUM_OUT-1:0] spread_down_mode,
	output logic [NUM_OUT-1:0] spread_up_shift,
	output logic [NUM_OUT-1:0] spread_preset,
	output logic [NUM_OUT*(STEP_W+8)-1:0] freq_offset,
	output logic [NUM_OUT*PHASE_W-1:0] phase_offset
);
	localparam int LC_W = $clog2(LOCK_CYCLES + 1);
	localparam int GAP_W = $clog2(PIN_GAP_CYC + 1);

	// true when the disable state field of output i selects always-on
	function automatic logic always_on(input logic [2*NUM_OUT-1:0] ds, input int i);
		return ds[2*i +: 2] == DIS_STATE_ALWAYS_ON;
	endfunction

	// ==========================================================
	// register port
	logic [7:0] soft_reg, soft_next;
	logic [7:0] rdata_reg, rdata_next;
	logic start_pulse;

	// write of the soft reset value starts the sequence; bit stays as written
	always_comb begin
		soft_next = soft_reg;
		rdata_next = rdata_reg;
		start_pulse = 1'b0;
		if (reg_wr && reg_addr == SOFT_RESET_CONTROL_ADDR) begin
			soft_next = reg_wdata;
			start_pulse = reg_wdata[SOFT_RESET_BIT];
		end
		if (reg_rd)
			rdata_next = (reg_addr == SOFT_RESET_CONTROL_ADDR) ? soft_reg : 8'h00;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			soft_reg <= SOFT_RESET_CONTROL_RST;
			rdata_reg <= 8'h00;
		end else begin
			soft_reg <= soft_next;
			rdata_reg <= rdata_next;
		end
	end

	// ==========================================================
	// soft reset sequencer; power-on reset runs the same sequence once
	coarc_state_t state_reg, state_next;
	logic [LC_W-1:0] cnt_reg, cnt_next;
	logic [NUM_OUT-1:0] off_reg, off_next;
	logic [NUM_OUT-1:0] en_reg, en_next;
	logic [NUM_OUT-1:0] align_reg, align_next;
	logic [NUM_OUT-1:0] fall_reg, fall_next;
	logic busy_reg, busy_next;
	logic por_reg, por_next;
	logic load_pulse;

	// configuration is only read, never rewritten, so a restart preserves it
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		off_next = off_reg;
		en_next = en_reg;
		align_next = '0;
		fall_next = fall_reg;
		busy_next = busy_reg;
		por_next = 1'b0;
		load_pulse = 1'b0;
		case (state_reg)
			COARC_IDLE: begin
				if (start_pulse || por_reg) begin
					state_next = COARC_OFF;
					busy_next = 1'b1;
				end
			end
			COARC_OFF: begin
				for (int i = 0; i < NUM_OUT; i++) begin
					off_next[i] = !always_on(dis_state, i);
					en_next[i] = always_on(dis_state, i);
				end
				cnt_next = '0;
				state_next = COARC_CAL;
			end
			COARC_CAL: begin
				if (cnt_reg == LC_W'(CAL_CYC - 1)) begin
					load_pulse = 1'b1;
					for (int i = 0; i < NUM_OUT; i++) begin
						align_next[i] = output_post_divider[i*DIV_SEL_W +: DIV_SEL_W] == '0;
						fall_next[i] = !out_invert[i];
					end
					cnt_next = '0;
					state_next = lock_wait_bypass ? COARC_ON : COARC_LOCK;
				end else begin
					cnt_next = cnt_reg + 1'b1;
				end
			end
			COARC_LOCK: begin
				// outputs other than always-on ones stay off for the whole lock window
				if (cnt_reg == LC_W'(LOCK_CYCLES - 1))
					state_next = COARC_ON;
				else
					cnt_next = cnt_reg + 1'b1;
			end
			COARC_ON: begin
				en_next = en_reg | off_reg;
				off_next = '0;
				busy_next = 1'b0;
				state_next = COARC_IDLE;
			end
			default: state_next = COARC_IDLE;
		endcase
		for (int i = 0; i < NUM_OUT; i++)
			if (always_on(dis_state, i))
				en_next[i] = 1'b1;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_reg <= COARC_IDLE;
			cnt_reg <= '0;
			off_reg <= '0;
			en_reg <= '0;
			align_reg <= '0;
			fall_reg <= '1;
			busy_reg <= 1'b0;
			por_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			off_reg <= off_next;
			en_reg <= en_next;
			align_reg <= align_next;
			fall_reg <= fall_next;
			busy_reg <= busy_next;
			por_reg <= por_next;
		end
	end

	// ==========================================================
	// step pins: rate limited to one accepted command per spacing window
	logic [GAP_W-1:0] fgap_reg, fgap_next, pgap_reg, pgap_next;
	logic fpin_up, fpin_dn, ppin_up, ppin_dn;

	// a pin pulse inside the window is dropped; faster than 1.5 MHz is out of spec anyway
	always_comb begin
		fpin_up = 1'b0;
		fpin_dn = 1'b0;
		ppin_up = 1'b0;
		ppin_dn = 1'b0;
		fgap_next = (fgap_reg != '0) ? fgap_reg - 1'b1 : fgap_reg;
		pgap_next = (pgap_reg != '0) ? pgap_reg - 1'b1 : pgap_reg;
		if (fgap_reg == '0 && (freq_step_up_pin ^ freq_step_down_pin)) begin
			fpin_up = freq_step_up_pin;
			fpin_dn = freq_step_down_pin;
			fgap_next = GAP_W'(PIN_GAP_CYC - 1);
		end
		if (pgap_reg == '0 && (phase_step_up_pin ^ phase_step_down_pin)) begin
			ppin_up = phase_step_up_pin;
			ppin_dn = phase_step_down_pin;
			pgap_next = GAP_W'(PIN_GAP_CYC - 1);
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			fgap_reg <= '0;
			pgap_reg <= '0;
		end else begin
			fgap_reg <= fgap_next;
			pgap_reg <= pgap_next;
		end
	end

	// ==========================================================
	// channels
	logic [NUM_OUT*(STEP_W+8)-1:0] foff_next;
	logic [NUM_OUT*PHASE_W-1:0] poff_next;
	logic [NUM_OUT*(STEP_W+8)-1:0] foff_reg;
	logic [NUM_OUT*PHASE_W-1:0] poff_reg;

	for (genvar g = 0; g < NUM_OUT; g++) begin : g_ch
		coarc_chan_if ch_if ();
		// only output zero listens to the step pins
		assign ch_if.freq_up = freq_up_cmd[g] | ((g == 0) & fpin_up);
		assign ch_if.freq_dn = freq_dn_cmd[g] | ((g == 0) & fpin_dn);
		assign ch_if.phase_up = phase_up_cmd[g] | ((g == 0) & ppin_up);
		assign ch_if.phase_dn = phase_dn_cmd[g] | ((g == 0) & ppin_dn);
		assign ch_if.load = load_pulse;
		assign ch_if.freq_step = freq_step_size;
		assign ch_if.phase_step = phase_step_size;
		assign ch_if.phase_init = phase_init[g*PHASE_W +: PHASE_W];
		// selections above divide by 32 are clamped to the largest ratio
		assign ch_if.div_sel = (output_post_divider[g*DIV_SEL_W +: DIV_SEL_W] > DIV_SEL_MAX) ?
			DIV_SEL_MAX : output_post_divider[g*DIV_SEL_W +: DIV_SEL_W];
		assign foff_next[g*(STEP_W+8) +: STEP_W+8] = ch_if.freq_offset;
		assign poff_next[g*PHASE_W +: PHASE_W] = ch_if.phase_now;
		coarc_chan u_chan (
			.clk(clk),
			.resetn(resetn),
			.ch(ch_if.chan)
		);
	end

	// ==========================================================
	// feedback routing and spread mode
	logic [NUM_OUT-1:0] fb_next, sdown_next, sshift_next, spre_next;

	always_comb begin
		for (int i = 0; i < NUM_OUT; i++) begin
			fb_next[i] = zero_delay_en && (zero_delay_sel == 2'(i));
			// later revision makes center spread by up-shift plus down spread
			sdown_next[i] = spread_en[i] && (LATER_REV || !spread_center[i]);
			sshift_next[i] = spread_en[i] && spread_center[i] && LATER_REV;
			spre_next[i] = spread_en[i] && !host_spread_prog[i];
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			feedback_route <= '0;
			spread_down_mode <= '0;
			spread_up_shift <= '0;
			spread_preset <= '0;
			foff_reg <= '0;
			poff_reg <= '0;
		end else begin
			feedback_route <= fb_next;
			spread_down_mode <= sdown_next;
			spread_up_shift <= sshift_next;
			spread_preset <= spre_next;
			foff_reg <= foff_next;
			poff_reg <= poff_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign out_enable = en_reg;
	assign align_req = align_reg;
	assign align_falling = fall_reg;
	assign cal_busy = busy_reg;
	assign freq_offset = foff_reg;
	assign phase_offset = poff_reg;
endmodule
`default_nettype wire

// ---- sim/coarc_ctrl_props.sv ----
// checker for the clock output adjust / reset control top
// assumes binding into coarc_ctrl with only its ports visible
`timescale 1ns/1ps
`default_nettype none
module coarc_ctrl_props
	import coarc_pkg::*;
#(
	parameter int LOCK_CYCLES = LOCK_WAIT_CYC
)(
	input wire logic clk,
	input wire logic resetn,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic lock_wait_bypass,
	input wire logic [2*NUM_OUT-1:0] dis_state,
	input wire logic [NUM_OUT-1:0] out_invert,
	input wire logic [NUM_OUT*DIV_SEL_W-1:0] output_post_divider,
	input wire logic zero_delay_en,
	input wire logic [1:0] zero_delay_sel,
	input wire logic [NUM_OUT-1:0] out_enable,
	input wire logic [NUM_OUT-1:0] align_req,
	input wire logic [NUM_OUT-1:0] align_falling,
	input wire logic cal_busy,
	input wire logic [NUM_OUT-1:0] feedback_route,
	input wire logic [NUM_OUT*PHASE_W-1:0] phase_offset
);
	// ==========
	// helper: busy length and a shadow of the control byte
	logic [31:0] busy_cnt_reg, busy_cnt_next;
	logic [7:0] shadow_reg, shadow_next;
	always_comb begin
		busy_cnt_next = cal_busy ? busy_cnt_reg + 32'h1 : 32'h0;
		shadow_next = shadow_reg;
		if (reg_wr && reg_addr == SOFT_RESET_CONTROL_ADDR) begin
			shadow_next = reg_wdata;
		end
		if (!resetn) begin
			busy_cnt_next = 32'h0;
			shadow_next = SOFT_RESET_CONTROL_RST;
		end
	end
	always_ff @(posedge clk) begin
		busy_cnt_reg <= busy_cnt_next;
		shadow_reg <= shadow_next;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	// ==========
	// register port, sequencer, phase range and feedback route
	soft_start_a: assert property (
		reg_wr && reg_addr == SOFT_RESET_CONTROL_ADDR && reg_wdata == SOFT_RESET_VALUE
		&& !cal_busy |=> cal_busy) else $error("control write did not start sequence");
	read_back_a: assert property (
		reg_rd && reg_addr == SOFT_RESET_CONTROL_ADDR |=> reg_rdata == shadow_reg)
		else $error("control byte read back differs");
	unmapped_read_a: assert property (
		reg_rd && reg_addr != SOFT_RESET_CONTROL_ADDR |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	off_in_seq_a: assert property (
		$past(cal_busy, 2) && cal_busy && dis_state[1:0] != DIS_STATE_ALWAYS_ON
		|-> !out_enable[0]) else $error("output zero running inside sequence");
	always_on_a: assert property (
		dis_state[7:6] == DIS_STATE_ALWAYS_ON && $past(out_enable[3]) |-> out_enable[3])
		else $error("always-on output switched off");
	lock_wait_a: assert property (
		$fell(cal_busy) && !lock_wait_bypass |-> busy_cnt_reg >= LOCK_CYCLES + CAL_CYC
		&& busy_cnt_reg <= LOCK_CYCLES + CAL_CYC + 8) else $error("lock wait length wrong");
	lock_bypass_a: assert property (
		$fell(cal_busy) && lock_wait_bypass |-> busy_cnt_reg <= CAL_CYC + 8)
		else $error("lock wait not skipped");
	restore_out_a: assert property (
		$fell(cal_busy) |-> out_enable == {NUM_OUT{1'b1}})
		else $error("outputs not restored at sequence end");
	align_div_a: assert property (
		output_post_divider[5:3] != 3'h0 |-> !align_req[1])
		else $error("align on divided output");
	align_pulse_a: assert property (
		align_req[0] |-> cal_busy ##1 !align_req[0]) else $error("align outside sequence");
	sync_edge_a: assert property (
		align_req[2] |=> align_falling[2] == !out_invert[2]) else $error("align edge wrong");
	phase_range_a: assert property (
		$signed(phase_offset[38:26]) >= PHASE_MIN && $signed(phase_offset[38:26]) <= PHASE_MAX)
		else $error("phase offset out of range");
	feedback_a: assert property (
		$past(resetn) && $past(zero_delay_en) |-> feedback_route == (4'h1 << $past(zero_delay_sel)))
		else $error("feedback route wrong");
	cover property ($fell(cal_busy) && lock_wait_bypass);
	cover property (align_req[0]);
	cover property (phase_offset[38:26] == PHASE_MIN);
endmodule
bind coarc_ctrl coarc_ctrl_props #(.LOCK_CYCLES(LOCK_CYCLES)) u_props (
	.clk, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .lock_wait_bypass,
	.dis_state, .out_invert, .output_post_divider, .zero_delay_en, .zero_delay_sel,
	.out_enable, .align_req, .align_falling, .cal_busy, .feedback_route, .phase_offset
);
`default_nettype wire

// ---- sim/coarc_host.sv ----
// host model on the byte register port of the control block
// assumes one shared clock; requests launch just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module coarc_host (
	input wire logic clk,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	// idle bus; released lines show the inverse so stale values are never reused
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// ==========
	// byte write, strobe held through the taking edge only
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk);
		reg_addr <= addr;
		reg_wdata <= data;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~addr;
		reg_wdata <= ~data;
	endtask
	// byte read, data stands from the cycle after the taking edge
	task automatic rd(input logic [7:0] addr, output logic [7:0] data);
		@(posedge clk);
		reg_addr <= addr;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~addr;
		@(posedge clk);
		#1;
		data = reg_rdata;
	endtask
endmodule
`default_nettype wire

// ---- sim/coarc_ctrl_tb.sv ----
// self-checking bench for the clock output adjust / reset control top
// assumes the host model on the register port and a shortened lock wait
`timescale 1ns/1ps
`default_nettype none
module coarc_ctrl_tb;
	import coarc_pkg::*;
	localparam int LOCK = 50;
	logic clk, resetn, reg_wr, reg_rd, lock_wait_bypass, zero_delay_en, cal_busy;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, dis_state, d;
	logic [3:0] out_invert, freq_up_cmd, freq_dn_cmd, phase_up_cmd, phase_dn_cmd, pins;
	logic [3:0] spread_en, spread_center, host_spread_prog, out_enable, align_req;
	logic [3:0] align_falling, feedback_route, spread_down_mode, spread_up_shift, spread_preset;
	logic [11:0] output_post_divider;
	logic [12:0] phase_step_size;
	logic [23:0] freq_step_size;
	logic [51:0] phase_init, phase_offset;
	logic [127:0] freq_offset;
	logic [1:0] zero_delay_sel;
	int fail_count = 0;
	int n_checks = 0;
	int n;
	coarc_ctrl #(.LOCK_CYCLES(LOCK)) dut (
		.clk, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .lock_wait_bypass,
		.dis_state, .out_invert, .output_post_divider, .freq_up_cmd, .freq_dn_cmd,
		.phase_up_cmd, .phase_dn_cmd, .freq_step_size, .phase_step_size, .phase_init,
		.freq_step_up_pin(pins[3]), .freq_step_down_pin(pins[2]),
		.phase_step_up_pin(pins[1]), .phase_step_down_pin(pins[0]),
		.zero_delay_en, .zero_delay_sel, .spread_en, .spread_center, .host_spread_prog,
		.out_enable, .align_req, .align_falling, .cal_busy, .feedback_route,
		.spread_down_mode, .spread_up_shift, .spread_preset, .freq_offset, .phase_offset
	);
	coarc_host host (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
	// ==========
	// clock and shared tasks
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic complete_run();
		$display("checks=%0d errors=%0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one-cycle pin pulse, then a gap that the spacing window may swallow
	task automatic pin(input logic [3:0] p, input int gap);
		@(posedge clk);
		pins <= p;
		@(posedge clk);
		pins <= 4'h0;
		repeat (gap) @(posedge clk);
		#1;
	endtask
	// bounded wait for a sequence to start and finish; cnt is its busy length
	task automatic wait_seq(output int cnt);
		cnt = 0;
		for (int i = 0; i < 20 && cal_busy !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		while (cal_busy === 1'b1 && cnt < 400) begin
			@(posedge clk);
			#1;
			cnt++;
		end
		if (cal_busy !== 1'b0 || cnt == 0) begin
			fail_count++;
			complete_run();
		end
	endtask
	// ==========
	// main sequence
	initial begin
		resetn = 1'b0;
		lock_wait_bypass = 1'b0;
		dis_state = 8'h00;
		out_invert = 4'h4;
		output_post_divider = 12'ha10; // codes 5,0,2,0 from output three down
		{freq_up_cmd, freq_dn_cmd, phase_up_cmd, phase_dn_cmd, pins} = 20'h0;
		freq_step_size = 24'h000100;
		phase_step_size = 13'h0100;
		phase_init = {13'h0000, 13'h0000, 13'h0020, 13'h0010};
		zero_delay_en = 1'b1;
		zero_delay_sel = 2'h3;
		spread_en = 4'hf;
		spread_center = 4'h5;
		host_spread_prog = 4'h3;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		wait_seq(n);
		chk(out_enable, 4'hf);
		chk(align_falling, 4'hb);
		chk(phase_offset[25:0], 26'h0000010);
		chk(feedback_route, 4'h8);
		chk({spread_down_mode, spread_up_shift, spread_preset}, 12'hf5c);
		host.rd(8'hf6, d);
		chk(d, 8'h00);
		host.rd(8'h10, d);
		chk(d, 8'h00);
		// back-to-back register steps; output one is divided by four
		@(posedge clk);
		freq_dn_cmd <= 4'h1;
		freq_up_cmd <= 4'h2;
		@(posedge clk);
		freq_up_cmd <= 4'h0;
		@(posedge clk);
		freq_dn_cmd <= 4'h0;
		repeat (4) @(posedge clk);
		#1;
		chk(freq_offset[31:0], 32'hfffffe00);
		chk(freq_offset[63:32], 32'h40);
		pin(4'h8, 10);
		chk(freq_offset[31:0], 32'hffffff00);
		pin(4'h8, 60);
		chk(freq_offset[31:0], 32'hffffff00);
		pin(4'h4, 70);
		chk(freq_offset[31:0], 32'hfffffe00);
		chk(freq_offset[63:32], 32'h40);
		pin(4'h2, 70);
		chk(phase_offset[12:0], 13'h0110);
		// nine steps down saturate output two
		@(posedge clk);
		phase_dn_cmd <= 4'h4;
		repeat (9) @(posedge clk);
		phase_dn_cmd <= 4'h0;
		repeat (4) @(posedge clk);
		#1;
		chk(phase_offset[38:26], 13'h1736);
		// soft reset with output three always on
		@(posedge clk);
		dis_state <= 8'hc0;
		host.wr(8'hf6, 8'h02);
		repeat (3) @(posedge clk);
		#1;
		chk(out_enable, 4'h8);
		wait_seq(n);
		chk(n > LOCK, 1);
		chk(out_enable, 4'hf);
		chk(phase_offset[12:0], 13'h0010);
		host.rd(8'hf6, d);
		chk(d, 8'h02);
		// bypassed lock wait, new feedback output and spread preset
		@(posedge clk);
		lock_wait_bypass <= 1'b1;
		zero_delay_sel <= 2'h1;
		host_spread_prog <= 4'h0;
		host.wr(8'hf6, 8'h02);
		wait_seq(n);
		chk(n < LOCK, 1);
		chk(feedback_route, 4'h2);
		chk(spread_preset, 4'hf);
		host.wr(8'h20, 8'h02);
		repeat (4) @(posedge clk);
		#1;
		chk(cal_busy, 1'b0);
		complete_run();
	end
endmodule
`default_nettype wire
